// *** hdl/drtas_pkg.sv ***
// Constants, field layout and codes of the debug ROM table register bank
package drtas_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int MAX_ENTRIES = 512;
  localparam int IDX_W = 9;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = IDX_LSB + IDX_W - 1;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ENTRY_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_TWO = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_LAST = 12'h7FC;
  localparam logic [ADDR_W-1:0] OFS_AUTH_STATE = 12'hFB8;

  // ----------------------------------------------------------------------
  // Descriptor field layout
  // ----------------------------------------------------------------------
  localparam int ENT_BASE_MSB = 31;
  localparam int ENT_BASE_LSB = 12;
  localparam int ENT_MBZ_HI_MSB = 11;
  localparam int ENT_MBZ_HI_LSB = 9;
  localparam int ENT_PD_MSB = 8;
  localparam int ENT_PD_LSB = 4;
  localparam int ENT_MBZ_LO = 3;
  localparam int ENT_PD_OK = 2;
  localparam int ENT_PRES_MSB = 1;
  localparam int ENT_PRES_LSB = 0;
  localparam int PD_W = ENT_PD_MSB - ENT_PD_LSB + 1;

  // Presence codes
  localparam logic [1:0] PRES_ABSENT_LAST = 2'h0;
  localparam logic [1:0] PRES_RESERVED = 2'h1;
  localparam logic [1:0] PRES_ABSENT_MORE = 2'h2;
  localparam logic [1:0] PRES_PRESENT = 2'h3;

  localparam logic [DATA_W-1:0] ENTRY_EMPTY = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Authentication status layout and codes
  // ----------------------------------------------------------------------
  localparam int AUTH_HYP_NONINV_LSB = 10;
  localparam int AUTH_HYP_INV_LSB = 8;
  localparam int AUTH_SEC_NONINV_LSB = 6;
  localparam int AUTH_SEC_INV_LSB = 4;
  localparam int AUTH_NONSEC_NONINV_LSB = 2;
  localparam int AUTH_NONSEC_INV_LSB = 0;
  localparam int AUTH_USED_MSB = 11;
  localparam int AUTH_FIELD_W = 2;
  localparam int AUTH_LIVE_FIELDS = 4;

  localparam logic [1:0] AUTH_NOT_IMPL = 2'h0;
  localparam logic [1:0] AUTH_RESERVED = 2'h1;
  localparam logic [1:0] AUTH_DISABLED = 2'h2;
  localparam logic [1:0] AUTH_ENABLED = 2'h3;

  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

endpackage : drtas_pkg

// *** hdl/drtas_entry_fmt.sv ***
// Descriptor formatter: forces the fixed fields of one table entry
`timescale 1ns/100ps

module drtas_entry_fmt
  import drtas_pkg::*;
(
  input wire logic [DATA_W-1:0] raw_in,
  output logic [DATA_W-1:0] entry_out
);

  // ----------------------------------------------------------------------
  // Field clean-up
  // ----------------------------------------------------------------------
  // Table contents come from a build parameter; cleaning here means a
  // careless table can never show nonzero must_be_zero bits.
  always_comb begin
    entry_out = '0;
    entry_out[ENT_BASE_MSB:ENT_BASE_LSB] =
      raw_in[ENT_BASE_MSB:ENT_BASE_LSB];
    entry_out[ENT_MBZ_HI_MSB:ENT_MBZ_HI_LSB] = '0;
    entry_out[ENT_MBZ_LO] = 1'b0;
    entry_out[ENT_PD_OK] = raw_in[ENT_PD_OK];
    if (raw_in[ENT_PD_OK]) begin
      entry_out[ENT_PD_MSB:ENT_PD_LSB] =
        raw_in[ENT_PD_MSB:ENT_PD_LSB];
    end else begin
      entry_out[ENT_PD_MSB:ENT_PD_LSB] = '0;
    end
    // Reserved presence code is never shown; walk continues past it
    if (raw_in[ENT_PRES_MSB:ENT_PRES_LSB] == PRES_RESERVED) begin
      entry_out[ENT_PRES_MSB:ENT_PRES_LSB] = PRES_ABSENT_MORE;
    end else begin
      entry_out[ENT_PRES_MSB:ENT_PRES_LSB] =
        raw_in[ENT_PRES_MSB:ENT_PRES_LSB];
    end
  end

endmodule : drtas_entry_fmt

// *** hdl/drtas_rom_table.sv ***
// Debug ROM table register bank with authentication status, APB4 slave
`timescale 1ns/100ps

// Summary of operation
// - Read-only 32-bit descriptors, entry two at 0x008, last at 0x7FC.
// - Descriptor upper twenty bits give the component base address.
// - Descriptor bits 11:9 and 3 read zero; software writes zeros.
// - Five-bit power-domain index selects one of 32 powerup handshakes.
// - Bit two flags a valid index; index reads zero when not valid.
// - Presence code: 0 absent last, 1 reserved, 2 absent more, 3 present.
// - Read-only authentication status at 0xFB8 mirrors live auth inputs.
// - Auth field codes: 0 not implemented, 1 reserved, 2 off, 3 on.
// - Hypervisor invasive and non-invasive fields always read zero.
// - Secure and non-secure fields follow live inputs, no reset value.
// - Auth status bits 31:12 reserved, read zero, writes ignored.
module drtas_rom_table
  import drtas_pkg::*;
#(
  parameter int NUM_ENTRIES = MAX_ENTRIES,
  parameter logic [DATA_W-1:0] ENTRY_TABLE [MAX_ENTRIES] =
    '{default: ENTRY_EMPTY},
  parameter bit SEC_AUTH_IMPL = 1'b1,
  parameter bit NONSEC_AUTH_IMPL = 1'b1
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // APB4 slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [2:0] pprot_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Authentication control levels
  input wire logic invasive_en_in,
  input wire logic noninvasive_en_in,
  input wire logic sec_invasive_en_in,
  input wire logic sec_noninvasive_en_in
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Register groups decoded from the word offset
  typedef enum logic [1:0] {
    DRTAS_SEL_NONE = 2'h0,
    DRTAS_SEL_ENTRY = 2'h1,
    DRTAS_SEL_AUTH = 2'h2
  } drtas_sel_t;

  function automatic logic [AUTH_FIELD_W-1:0] drtas_auth_code(
    input logic impl,
    input logic on
  );
    logic [AUTH_FIELD_W-1:0] code;
    code = AUTH_NOT_IMPL;
    if (impl) begin
      code = on ? AUTH_ENABLED : AUTH_DISABLED;
    end
    return code;
  endfunction : drtas_auth_code

  // Low offset bits are ignored, so any byte lane hits its word
  function automatic logic drtas_is_entry(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_LSB] <= OFS_ENTRY_LAST[ADDR_W-1:IDX_LSB];
  endfunction : drtas_is_entry

  function automatic logic drtas_is_auth(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_LSB] == OFS_AUTH_STATE[ADDR_W-1:IDX_LSB];
  endfunction : drtas_is_auth

  function automatic drtas_sel_t drtas_decode(
    input logic [ADDR_W-1:0] a
  );
    drtas_sel_t sel;
    sel = DRTAS_SEL_NONE;
    if (drtas_is_entry(a)) begin
      sel = DRTAS_SEL_ENTRY;
    end else if (drtas_is_auth(a)) begin
      sel = DRTAS_SEL_AUTH;
    end
    return sel;
  endfunction : drtas_decode

  // ----------------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------------
  logic setup_rd;
  logic [IDX_W-1:0] entry_idx;
  drtas_sel_t rd_sel;
  logic [DATA_W-1:0] entry_raw;
  logic [DATA_W-1:0] entry_clean;
  logic [DATA_W-1:0] auth_word;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] prdata_r;

  // Data is latched in the setup phase so it is ready with zero waits
  assign setup_rd = psel_in && !penable_in && !pwrite_in;
  assign rd_sel = drtas_decode(paddr_in);

  // ----------------------------------------------------------------------
  // Descriptor storage
  // ----------------------------------------------------------------------
  // Slots past NUM_ENTRIES read as absent-and-last, ending any walk
  localparam int TABLE_DEPTH =
    (NUM_ENTRIES < MAX_ENTRIES) ? NUM_ENTRIES : MAX_ENTRIES;
  wire logic [DATA_W-1:0] entry_rom [MAX_ENTRIES];

  for (genvar k = 0; k < MAX_ENTRIES; k++) begin : g_entry_rom
    if (k < TABLE_DEPTH) begin : g_used
      assign entry_rom[k] = ENTRY_TABLE[k];
    end else begin : g_unused
      assign entry_rom[k] = ENTRY_EMPTY;
    end
  end

  // ----------------------------------------------------------------------
  // Descriptor lookup
  // ----------------------------------------------------------------------
  assign entry_idx = paddr_in[IDX_MSB:IDX_LSB];
  assign entry_raw = entry_rom[entry_idx];

  drtas_entry_fmt u_entry_fmt (
    .raw_in(entry_raw),
    .entry_out(entry_clean)
  );

  // ----------------------------------------------------------------------
  // Live authentication levels
  // ----------------------------------------------------------------------
  // Secure debug also needs the matching non-secure permission
  logic nonsec_invasive_on;
  logic nonsec_noninvasive_on;
  logic sec_invasive_on;
  logic sec_noninvasive_on;
  logic [AUTH_LIVE_FIELDS-1:0] auth_on;
  logic [AUTH_LIVE_FIELDS-1:0] auth_impl;

  assign nonsec_invasive_on = invasive_en_in;
  assign nonsec_noninvasive_on = invasive_en_in || noninvasive_en_in;
  assign sec_invasive_on = invasive_en_in && sec_invasive_en_in;
  assign sec_noninvasive_on = nonsec_noninvasive_on &&
    (sec_invasive_en_in || sec_noninvasive_en_in);

  // Index order follows field order from bit zero upwards
  assign auth_on = {sec_noninvasive_on, sec_invasive_on,
    nonsec_noninvasive_on, nonsec_invasive_on};
  assign auth_impl = {SEC_AUTH_IMPL, SEC_AUTH_IMPL,
    NONSEC_AUTH_IMPL, NONSEC_AUTH_IMPL};

  // ----------------------------------------------------------------------
  // Authentication field encode
  // ----------------------------------------------------------------------
  localparam int LIVE_W = AUTH_LIVE_FIELDS * AUTH_FIELD_W;
  wire logic [LIVE_W-1:0] auth_live;

  for (genvar g = 0; g < AUTH_LIVE_FIELDS; g++) begin : g_auth_field
    assign auth_live[g*AUTH_FIELD_W +: AUTH_FIELD_W] =
      drtas_auth_code(auth_impl[g], auth_on[g]);
  end

  // ----------------------------------------------------------------------
  // Authentication status word
  // ----------------------------------------------------------------------
  // Fields are combinational from the pins, so they carry no reset value
  always_comb begin
    auth_word = '0;
    auth_word[AUTH_HYP_NONINV_LSB +: AUTH_FIELD_W] = AUTH_NOT_IMPL;
    auth_word[AUTH_HYP_INV_LSB +: AUTH_FIELD_W] = AUTH_NOT_IMPL;
    auth_word[AUTH_NONSEC_INV_LSB +: LIVE_W] = auth_live;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Unmapped offsets read zero without error; debuggers probe freely
  always_comb begin
    rdata_nxt = RDATA_RESET;
    unique case (rd_sel)
      DRTAS_SEL_ENTRY: begin
        rdata_nxt = entry_clean;
      end
      DRTAS_SEL_AUTH: begin
        rdata_nxt = auth_word;
      end
      DRTAS_SEL_NONE: begin
        rdata_nxt = RDATA_RESET;
      end
      default: begin
        rdata_nxt = RDATA_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------------
  // Writes never reach storage: every register here is read-only
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_r <= RDATA_RESET;
    end else if (setup_rd) begin
      prdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------
  // No wait states and no errors: every read completes in two cycles
  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

endmodule : drtas_rom_table

// *** testbench/drtas_monitor.sv ***
// Port checker for the ROM table bank
`timescale 1ns/100ps
module drtas_monitor
  import drtas_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic invasive_en_in,
  input wire logic sec_invasive_en_in
);
  // ------
  // Read setup decode
  // ------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire rd = psel_in && !penable_in && !pwrite_in;
  wire ent = rd && !paddr_in[11];
  wire au = rd && paddr_in == OFS_AUTH_STATE;
  a_auth_hyp_zero: assert property (au |=> prdata_out[11:8] == 4'h0)
    else $error("hypervisor fields not zero");
  a_auth_resv_zero: assert property (au |=>
    prdata_out[31:12] == 20'h0) else $error("auth upper bits not zero");
  a_auth_nonsec_live: assert property (au |=> prdata_out[1:0] ==
    ($past(invasive_en_in) ? 2'h3 : 2'h2)) else $error("nonsec field wrong");
  a_auth_sec_live: assert property (au |=> prdata_out[5:4] ==
    (($past(invasive_en_in) && $past(sec_invasive_en_in)) ? 2'h3 : 2'h2))
    else $error("secure field wrong");
  a_entry_mbz_zero: assert property (ent |=> prdata_out[11:9] == 3'h0
    && !prdata_out[3]) else $error("entry zero bits set");
  a_index_gated: assert property (ent |=> prdata_out[2]
    || prdata_out[8:4] == 5'h00) else $error("index without valid");
  a_pres_code: assert property (ent |=> prdata_out[1:0] != 2'h1)
    else $error("reserved presence code");
  a_data_holds: assert property (!rd |=> $stable(prdata_out))
    else $error("read data moved");
  a_okay_resp: assert property (pready_out && !pslverr_out)
    else $error("wait or error response");
  c_auth: cover property (au);
  c_entry: cover property (ent);
  c_last: cover property (rd && paddr_in == OFS_ENTRY_LAST);
endmodule : drtas_monitor

// *** testbench/drtas_apb_master.sv ***
// Debug bus master model for APB transfers
`timescale 1ns/100ps
module drtas_apb_master
  import drtas_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [DATA_W-1:0] prdata_in,
  input wire logic pready_in,
  output logic psel_out = 1'b0,
  output logic penable_out = 1'b0,
  output logic pwrite_out = 1'b0,
  output logic [ADDR_W-1:0] paddr_out = 12'h000,
  output logic [DATA_W-1:0] pwdata_out = 32'h0000_0000
);
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    output logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    #1;
    psel_out = 1'b1;
    pwrite_out = w;
    paddr_out = a;
    pwdata_out = 32'hFFFF_F1F7;
    @(posedge core_clk_in);
    #1;
    penable_out = 1'b1;
    do @(posedge core_clk_in); while (pready_in !== 1'b1);
    d = prdata_in;
    #1;
    psel_out = 1'b0;
    penable_out = 1'b0;
    // Released lines show the inverse so stale values never match
    paddr_out = ~a;
    pwdata_out = ~pwdata_out;
  endtask : xfer
endmodule : drtas_apb_master

// *** testbench/test_drtas_rom_table.sv ***
// Self-checking bench for the ROM table register bank
`timescale 1ns/100ps
module test_drtas_rom_table import drtas_pkg::*; ();
  typedef struct packed {logic [11:0] a; logic [31:0] v;} drtas_row_t;
  drtas_row_t rows [7] = '{'{12'h000, 32'h0}, '{12'h004, 32'h2},
    '{12'h008, 32'hABCD_E1F6}, '{12'h00C, 32'h3003},
    '{12'h7FC, 32'h1234_51F7}, '{12'h800, 32'h0}, '{12'hFBC, 32'h0}};
  logic clk, rstn, inv = 0, ninv = 0, sinv = 0, snin = 0, psel, pen, pwr;
  logic rdy, err;
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pwd, prd, d, e;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  drtas_rom_table #(.ENTRY_TABLE('{1: 32'h11, 2: 32'hABCD_EFFD,
    3: 32'h3FB3, 511: 32'h1234_51F7, default: ENTRY_EMPTY})) u_drtas_rom_table (
    .core_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hF),
    .pprot_in(3'h0), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
    .invasive_en_in(inv), .noninvasive_en_in(ninv),
    .sec_invasive_en_in(sinv), .sec_noninvasive_en_in(snin));
  drtas_apb_master u_drtas_apb_master (.core_clk_in(clk), .prdata_in(prd),
    .pready_in(rdy), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(pa), .pwdata_out(pwd));
  function automatic logic [1:0] code(input logic x);
    return x ? AUTH_ENABLED : AUTH_DISABLED;
  endfunction : code
  task automatic check(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Run is short; the ceiling only catches a stuck handshake
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    rstn = 0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1;
    check("reset rdata", prd, RDATA_RESET);
    check("response", {30'h0, rdy, err}, 32'h2);
    u_drtas_apb_master.xfer(1'b1, OFS_ENTRY_TWO, d);
    u_drtas_apb_master.xfer(1'b1, OFS_AUTH_STATE, d);
    foreach (rows[i]) begin
      u_drtas_apb_master.xfer(1'b0, rows[i].a, d);
      check("entry", d, rows[i].v);
    end
    for (int i = 0; i < 16; i++) begin
      {inv, ninv, sinv, snin} = i[3:0];
      e = {24'h0, code((inv | ninv) & (sinv | snin)), code(inv & sinv),
        code(inv | ninv), code(inv)};
      u_drtas_apb_master.xfer(1'b0, OFS_AUTH_STATE, d);
      check("auth", d, e);
    end
    @(posedge clk);
    #1;
    rstn = 0;
    @(posedge clk);
    #1;
    check("second reset", prd, RDATA_RESET);
    rstn = 1;
    u_drtas_apb_master.xfer(1'b0, OFS_ENTRY_LAST, d);
    check("read after reset", d, 32'h1234_51F7);
    final_report();
  end
endmodule : test_drtas_rom_table
bind drtas_rom_table drtas_monitor u_drtas_monitor (.core_clk_in,
  .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .pslverr_out, .invasive_en_in, .sec_invasive_en_in);
